// ===== sim/sbsr_host_model.sv
// Host side model: response text sink and standard event set
`timescale 1ns/100ps
`default_nettype none
module sbsr_host_model (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        slow_in,
   input  wire logic        rsp_valid_in,
   input  wire logic [7:0]  rsp_char_in,
   input  wire logic        rsp_last_in,
   output logic             rsp_ready_out,
   output logic [79:0]      text_out,
   output logic             done_out,
   input  wire logic        std_set_in,
   input  wire logic        std_clear_in,
   output logic [7:0]       std_value_out,
   output logic             std_summary_out
);
   logic stall_q;

   // Slow mode drops ready on every other clock cycle
   assign rsp_ready_out = !(slow_in && stall_q);
   assign std_summary_out = |std_value_out;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stall_q <= 1'b0;
         text_out <= '0;
         done_out <= 1'b0;
         std_value_out <= 8'h00;
      end else begin
         stall_q <= !stall_q;
         if (rsp_valid_in && rsp_ready_out) begin
            if (done_out) begin
               text_out <= {72'h0, rsp_char_in};
            end else begin
               text_out <= {text_out[71:0], rsp_char_in};
            end
            done_out <= rsp_last_in;
         end
         // Reading the event register empties it
         if (std_clear_in) begin
            std_value_out <= 8'h00;
         end else if (std_set_in) begin
            std_value_out <= std_value_out | 8'h24;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Testbench of the status byte and service request block
`timescale 1ns/100ps
`default_nettype none
module testbench
   import sbsr_pkg::*;
;
   typedef struct packed {
      logic [5:0] s;
      logic [7:0] m;
      logic [7:0] b;
   } sbsr_row_t;
   logic clk, rst_n, cmd_v, slow, std_set, std_sum, done;
   logic [5:0] sum;
   sbsr_cmd_t cmd;
   sbsr_summary_t summ;
   logic rdy, rv, rr, rl, pv, clr, master, srq;
   logic [7:0] rc, pb, sb, mask, stdv;
   logic [79:0] text;
   int bad_count, n_compared, cyc;
   sbsr_row_t rows[10] = '{
      '{6'h01, 8'h01, 8'h41}, '{6'h02, 8'h00, 8'h04},
      '{6'h04, 8'h08, 8'h48}, '{6'h08, 8'hf7, 8'h50},
      '{6'h10, 8'h20, 8'h60}, '{6'h20, 8'h7f, 8'h80},
      '{6'h3f, 8'h02, 8'hbd}, '{6'h3f, 8'h40, 8'hbd},
      '{6'h00, 8'hff, 8'h00}, '{6'h3f, 8'h00, 8'hbd}};

   assign summ = sbsr_summary_t'(sum | {1'b0, std_sum, 4'h0});
   always #50 clk = !clk;

   sbsr_status_byte dut (
      .sys_clk_in(clk), .rst_n_in(rst_n), .summary_in(summ),
      .std_event_value_in(stdv), .cmd_valid_in(cmd_v), .cmd_in(cmd),
      .cmd_ready_out(rdy), .rsp_valid_out(rv), .rsp_ready_in(rr),
      .rsp_char_out(rc), .rsp_last_out(rl), .poll_valid_out(pv),
      .poll_byte_out(pb), .std_event_clear_out(clr),
      .status_summary_byte_out(sb), .service_request_mask_out(mask),
      .master_summary_flag_out(master), .srq_out(srq));

   sbsr_host_model host (
      .clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
      .rsp_valid_in(rv), .rsp_char_in(rc), .rsp_last_in(rl),
      .rsp_ready_out(rr), .text_out(text), .done_out(done),
      .std_set_in(std_set), .std_clear_in(clr),
      .std_value_out(stdv), .std_summary_out(std_sum));

   // ==========================================
   // Checking and command tasks
   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic send(input sbsr_cmd_op_t op, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk);
      cmd_v = 1'b1;
      cmd.op = op;
      cmd.data = d;
      while (!rdy && n < 500) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      cmd_v = 1'b0;
   endtask

   // Expected text: header, then digits without leading zeros
   function automatic logic [79:0] txt(input logic [7:0] v, input int f);
      logic [79:0] t;
      logic [7:0] d[8];
      int r, n, x;
      t = '0;
      x = v;
      n = 0;
      r = (f == 1) ? 16 : (f == 2) ? 8 : (f == 3) ? 2 : 10;
      if (f == 1) t = 80'h2348;
      if (f == 2) t = 80'h2351;
      if (f == 3) t = 80'h2342;
      do begin
         d[n] = (x % r < 10) ? 8'h30 + x % r : 8'h37 + x % r;
         x = x / r;
         n++;
      end while (x > 0);
      for (int i = n - 1; i >= 0; i--) t = {t[71:0], d[i]};
      return t;
   endfunction

   task automatic query(input sbsr_cmd_op_t op, input int f,
                        input logic [7:0] v);
      int n;
      n = 0;
      send(op, 8'h00);
      while (!(rdy && done) && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk(text, txt(v, f));
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      clk = 0; rst_n = 0; cmd_v = 0; cmd = '0; sum = '0;
      slow = 0; std_set = 0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1;
      chk(mask, 8'h00);
      chk(sb, 8'h00);
      chk(srq, 1'b0);
      query(SBSR_CMD_STATUS_QUERY, 0, 8'h00);
      $display("test reset done");
      foreach (rows[i]) begin
         sum = rows[i].s;
         send(SBSR_CMD_MASK_WRITE, rows[i].m);
         chk(mask, rows[i].m);
         chk(sb, rows[i].b);
         chk(master, rows[i].b[6]);
      end
      $display("test table done");
      sum = 6'h16;
      send(SBSR_CMD_MASK_WRITE, 8'h04);
      for (int f = 0; f < 4; f++) begin
         slow = f[0];
         send(SBSR_CMD_FORMAT_SET, 8'(f));
         query(SBSR_CMD_STATUS_QUERY, f, 8'h6c);
      end
      send(SBSR_CMD_FORMAT_SET, 8'h03);
      send(SBSR_CMD_MASK_WRITE, 8'hff);
      query(SBSR_CMD_MASK_QUERY, 3, 8'hff);
      send(SBSR_CMD_FORMAT_SET, 8'h00);
      send(SBSR_CMD_MASK_WRITE, 8'h00);
      query(SBSR_CMD_MASK_QUERY, 0, 8'h00);
      $display("test format done");
      sum = 6'h00;
      send(SBSR_CMD_MASK_WRITE, 8'h01);
      send(SBSR_CMD_POLL, 8'h00);
      chk(srq, 1'b0);
      sum = 6'h01;
      @(negedge clk);
      chk(srq, 1'b1);
      send(SBSR_CMD_POLL, 8'h00);
      chk(pv, 1'b1);
      chk(pb, 8'h41);
      chk(srq, 1'b0);
      chk(master, 1'b1);
      sum = 6'h00;
      #1 chk(master, 1'b0);
      @(negedge clk);
      sum = 6'h01;
      @(negedge clk);
      chk(srq, 1'b1);
      $display("test poll done");
      sum = 6'h00;
      send(SBSR_CMD_MASK_WRITE, 8'h20);
      std_set = 1;
      @(negedge clk);
      std_set = 0;
      #1 chk(sb, 8'h60);
      send(SBSR_CMD_STD_QUERY, 8'h00);
      chk(clr, 1'b1);
      query(SBSR_CMD_NOP, 0, 8'h24);
      chk(sb, 8'h00);
      $display("test standard event done");
      send(SBSR_CMD_MASK_WRITE, 8'hff);
      chk(srq, 1'b1);
      rst_n = 0;
      @(negedge clk);
      rst_n = 1;
      chk(mask, 8'h00);
      chk(srq, 1'b0);
      chk(sb, 8'h00);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ===== verilog/sbsr_consts.svh
// Constants of the status byte and service request block
//
// Overview of operation
// - Summary bits B0,B2,B3,B4,B5,B7 follow their summary inputs, never latched.
// - Reading the standard event register clears it, dropping the event summary bit.
// - B0 is high while the measurement set reports an enabled event.
// - B2 is high while the error queue holds a message, else low.
// - B3 is high while the questionable set reports an enabled event.
// - B4 is high while the output queue holds a response, else low.
// - B5 is high while the standard event set reports an enabled event.
// - B7 is high while the operation set reports an enabled event.
// - B6 is the OR of each summary bit ANDed with its mask bit.
// - B6 reads as request-service on a poll, master summary on a query.
// - Status byte and 8-bit mask; host writes mask and reads it back.
// - Mask is zero after power-up and after a write of zero.
// - Each register is readable by query, returning which bits are set.
// - Read-back value is bit-weighted, B0 the least significant digit.
// - Read-back format is binary, decimal, hex or octal; decimal by default.
// - Non-decimal read-back carries header #B, #H or #Q.
// - A rising enabled summary bit sets request-service and raises a request.
// - A serial poll clears request-service; master summary stays while bits set.
// - At power-up every register is zero and both queues are empty.
`ifndef SBSR_CONSTS_SVH
`define SBSR_CONSTS_SVH

// Status byte bit positions
`define SB_MEAS     0
`define SB_UNUSED   1
`define SB_ERR      2
`define SB_QUES     3
`define SB_MSG      4
`define SB_STD      5
`define SB_SERVICE  6
`define SB_OPER     7

`define BYTE_W      8
`define TEXT_LEN    10
`define MASK_RESET  8'h00

// Text characters of the read-back
`define CH_HASH     8'h23
`define CH_BIN      8'h42
`define CH_HEX      8'h48
`define CH_OCT      8'h51
`define CH_ZERO     8'h30
`define CH_ALPHA    8'h37
`define HDR_LEN     2
`define DEC_DIGITS  3
`define RADIX_DEC   10
`define RADIX_BIN_K 1
`define RADIX_OCT_K 3
`define RADIX_HEX_K 4

`endif

// ===== verilog/sbsr_pkg.sv
// Types of the status byte and service request block
`include "sbsr_consts.svh"
package sbsr_pkg;

   typedef enum logic [2:0] {
      SBSR_CMD_NOP,
      SBSR_CMD_MASK_WRITE,
      SBSR_CMD_MASK_QUERY,
      SBSR_CMD_STATUS_QUERY,
      SBSR_CMD_STD_QUERY,
      SBSR_CMD_POLL,
      SBSR_CMD_FORMAT_SET
   } sbsr_cmd_op_t;

   typedef enum logic [1:0] {
      SBSR_FMT_DEC,
      SBSR_FMT_HEX,
      SBSR_FMT_OCT,
      SBSR_FMT_BIN
   } sbsr_fmt_t;

   typedef struct packed {
      logic operation_summary;
      logic standard_event_summary;
      logic output_message_ready;
      logic questionable_summary;
      logic error_queue_nonempty;
      logic measurement_summary;
   } sbsr_summary_t;

   typedef struct packed {
      sbsr_cmd_op_t              op;
      logic [`BYTE_W-1:0]        data;
   } sbsr_cmd_t;

   typedef struct packed {
      logic [`TEXT_LEN-1:0][7:0] ch;
      logic [3:0]                len;
   } sbsr_text_t;

endpackage

// ===== verilog/sbsr_status_byte.sv
// Status byte, service request mask, request flag and formatted read-back
`timescale 1ns/100ps
`default_nettype none
`include "sbsr_consts.svh"

module sbsr_status_byte
   import sbsr_pkg::*;
#(
   parameter int unsigned BYTE_W = `BYTE_W
) (
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_n_in,
   input  wire sbsr_summary_t        summary_in,
   input  wire logic [BYTE_W-1:0]    std_event_value_in,
   input  wire logic                 cmd_valid_in,
   input  wire sbsr_cmd_t            cmd_in,
   output logic                      cmd_ready_out,
   output logic                      rsp_valid_out,
   input  wire logic                 rsp_ready_in,
   output logic [7:0]                rsp_char_out,
   output logic                      rsp_last_out,
   output logic                      poll_valid_out,
   output logic [BYTE_W-1:0]         poll_byte_out,
   output logic                      std_event_clear_out,
   output logic [BYTE_W-1:0]         status_summary_byte_out,
   output logic [BYTE_W-1:0]         service_request_mask_out,
   output logic                      master_summary_flag_out,
   output logic                      srq_out
);

   if (BYTE_W != `BYTE_W) begin
      $error("sbsr_status_byte serves only an 8-bit status byte");
   end

   // ==========================================================
   // Summary byte
   // ==========================================================
   logic [BYTE_W-1:0] summ_bits;
   logic [BYTE_W-1:0] enabled_bits;
   logic              master_summary_flag;
   logic [BYTE_W-1:0] service_request_mask_q;
   logic [BYTE_W-1:0] service_request_mask_d;

   always_comb begin
      summ_bits              = '0;
      summ_bits[`SB_MEAS]    = summary_in.measurement_summary;
      summ_bits[`SB_UNUSED]  = 1'b0;
      summ_bits[`SB_ERR]     = summary_in.error_queue_nonempty;
      summ_bits[`SB_QUES]    = summary_in.questionable_summary;
      summ_bits[`SB_MSG]     = summary_in.output_message_ready;
      summ_bits[`SB_STD]     = summary_in.standard_event_summary;
      summ_bits[`SB_OPER]    = summary_in.operation_summary;
   end

   // B6 itself never feeds its own OR
   always_comb begin
      enabled_bits          = summ_bits & service_request_mask_q;
      enabled_bits[`SB_SERVICE] = 1'b0;
      enabled_bits[`SB_UNUSED] = 1'b0;
      master_summary_flag   = |enabled_bits;
   end

   // ==========================================================
   // Mask, format and request flag
   // ==========================================================
   sbsr_fmt_t         fmt_q;
   sbsr_fmt_t         fmt_d;
   logic [BYTE_W-1:0] enabled_prev_q;
   logic [BYTE_W-1:0] enabled_prev_d;
   logic              request_service_flag_q;
   logic              request_service_flag_d;
   logic              cmd_take;
   logic              rise_any;
   logic              poll_take;

   assign cmd_take  = cmd_valid_in && cmd_ready_out;
   assign poll_take = cmd_take && (cmd_in.op == SBSR_CMD_POLL);
   assign rise_any  = |(enabled_bits & ~enabled_prev_q);

   always_comb begin
      service_request_mask_d = service_request_mask_q;
      fmt_d                  = fmt_q;
      enabled_prev_d         = enabled_bits;
      request_service_flag_d = request_service_flag_q;
      if (cmd_take && cmd_in.op == SBSR_CMD_MASK_WRITE) begin
         service_request_mask_d = cmd_in.data;
      end
      if (cmd_take && cmd_in.op == SBSR_CMD_FORMAT_SET) begin
         fmt_d = sbsr_fmt_t'(cmd_in.data[1:0]);
      end
      if (poll_take) begin
         request_service_flag_d = 1'b0;
      end
      // A new rising bit wins over the poll's clear
      if (rise_any) begin
         request_service_flag_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         service_request_mask_q <= `MASK_RESET;
         fmt_q                  <= SBSR_FMT_DEC;
         enabled_prev_q         <= '0;
         request_service_flag_q <= 1'b0;
      end else begin
         service_request_mask_q <= service_request_mask_d;
         fmt_q                  <= fmt_d;
         enabled_prev_q         <= enabled_prev_d;
         request_service_flag_q <= request_service_flag_d;
      end
   end

   // ==========================================================
   // Read-back text
   // ==========================================================
   function automatic logic [7:0] digit_char(input logic [3:0] d);
      if (d < 4'ha) begin
         digit_char = `CH_ZERO + {4'h0, d};
      end else begin
         digit_char = `CH_ALPHA + {4'h0, d};
      end
   endfunction

   // Bit-weighted value, most significant digit first, no leading zeros
   function automatic sbsr_text_t render(input logic [7:0] v,
                                         input sbsr_fmt_t  f);
      sbsr_text_t       t;
      logic [7:0][3:0]  dg;
      logic [7:0]       msk;
      int unsigned      k;
      int unsigned      n;
      int unsigned      h;
      t   = '0;
      dg  = '0;
      msk = 8'h00;
      k   = 0;
      n   = 1;
      h   = 0;
      case (f)
         SBSR_FMT_BIN: begin
            k = `RADIX_BIN_K;
         end
         SBSR_FMT_OCT: begin
            k = `RADIX_OCT_K;
         end
         SBSR_FMT_HEX: begin
            k = `RADIX_HEX_K;
         end
         default: begin
            k = 0;
         end
      endcase
      if (k == 0) begin
         dg[0] = 4'(v % `RADIX_DEC);
         dg[1] = 4'((v / `RADIX_DEC) % `RADIX_DEC);
         dg[2] = 4'(v / (`RADIX_DEC * `RADIX_DEC));
         if (dg[2] != 4'h0) begin
            n = `DEC_DIGITS;
         end else if (dg[1] != 4'h0) begin
            n = `DEC_DIGITS - 1;
         end
      end else begin
         msk = 8'((1 << k) - 1);
         for (int i = 0; i < 8; i++) begin
            dg[i] = 4'((v >> (i * k)) & msk);
            if (dg[i] != 4'h0) begin
               n = i + 1;
            end
         end
         t.ch[0] = `CH_HASH;
         case (f)
            SBSR_FMT_BIN: begin
               t.ch[1] = `CH_BIN;
            end
            SBSR_FMT_OCT: begin
               t.ch[1] = `CH_OCT;
            end
            default: begin
               t.ch[1] = `CH_HEX;
            end
         endcase
         h = `HDR_LEN;
      end
      for (int j = 0; j < 8; j++) begin
         if (j < n) begin
            t.ch[h + j] = digit_char(dg[n - 1 - j]);
         end
      end
      t.len = 4'(h + n);
      return t;
   endfunction

   // ==========================================================
   // Command decode and response sender
   // ==========================================================
   typedef enum logic {
      SBSR_ST_IDLE,
      SBSR_ST_SEND
   } sbsr_state_t;

   sbsr_state_t       state_q;
   sbsr_state_t       state_d;
   sbsr_text_t        text_q;
   sbsr_text_t        text_d;
   logic [3:0]        idx_q;
   logic [3:0]        idx_d;
   logic [7:0]        char_q;
   logic [7:0]        char_d;
   logic              last_q;
   logic              last_d;
   logic              poll_valid_q;
   logic              poll_valid_d;
   logic [BYTE_W-1:0] poll_byte_q;
   logic [BYTE_W-1:0] poll_byte_d;
   logic              std_clear_q;
   logic              std_clear_d;
   logic [BYTE_W-1:0] qry_val;
   logic              qry_take;
   sbsr_text_t        qry_text;

   always_comb begin
      qry_take = 1'b0;
      qry_val  = '0;
      case (cmd_in.op)
         SBSR_CMD_STATUS_QUERY: begin
            qry_take = cmd_take;
            qry_val  = summ_bits;
            qry_val[`SB_SERVICE] = master_summary_flag;
         end
         SBSR_CMD_MASK_QUERY: begin
            qry_take = cmd_take;
            qry_val  = service_request_mask_q;
         end
         SBSR_CMD_STD_QUERY: begin
            qry_take = cmd_take;
            qry_val  = std_event_value_in;
         end
         default: begin
            qry_take = 1'b0;
         end
      endcase
      qry_text = render(qry_val, fmt_q);
   end

   always_comb begin
      state_d      = state_q;
      text_d       = text_q;
      idx_d        = idx_q;
      char_d       = char_q;
      last_d       = last_q;
      poll_valid_d = 1'b0;
      poll_byte_d  = poll_byte_q;
      std_clear_d  = 1'b0;
      case (state_q)
         SBSR_ST_IDLE: begin
            if (qry_take) begin
               state_d = SBSR_ST_SEND;
               text_d  = qry_text;
               idx_d   = 4'h0;
               char_d  = qry_text.ch[0];
               last_d  = (qry_text.len == 4'h1);
               std_clear_d = (cmd_in.op == SBSR_CMD_STD_QUERY);
            end
            if (poll_take) begin
               poll_valid_d = 1'b1;
               poll_byte_d  = summ_bits;
               poll_byte_d[`SB_SERVICE] = request_service_flag_q;
            end
         end
         SBSR_ST_SEND: begin
            if (rsp_ready_in) begin
               if (last_q) begin
                  state_d = SBSR_ST_IDLE;
               end else begin
                  idx_d  = idx_q + 4'h1;
                  char_d = text_q.ch[idx_q + 4'h1];
                  last_d = ((idx_q + 4'h2) == text_q.len);
               end
            end
         end
         default: begin
            state_d = SBSR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q      <= SBSR_ST_IDLE;
         text_q       <= '0;
         idx_q        <= 4'h0;
         char_q       <= 8'h00;
         last_q       <= 1'b0;
         poll_valid_q <= 1'b0;
         poll_byte_q  <= '0;
         std_clear_q  <= 1'b0;
      end else begin
         state_q      <= state_d;
         text_q       <= text_d;
         idx_q        <= idx_d;
         char_q       <= char_d;
         last_q       <= last_d;
         poll_valid_q <= poll_valid_d;
         poll_byte_q  <= poll_byte_d;
         std_clear_q  <= std_clear_d;
      end
   end

   assign cmd_ready_out            = (state_q == SBSR_ST_IDLE);
   assign rsp_valid_out            = (state_q == SBSR_ST_SEND);
   assign rsp_char_out             = char_q;
   assign rsp_last_out             = last_q;
   assign poll_valid_out           = poll_valid_q;
   assign poll_byte_out            = poll_byte_q;
   assign std_event_clear_out      = std_clear_q;
   assign service_request_mask_out = service_request_mask_q;
   assign master_summary_flag_out  = master_summary_flag;
   assign srq_out                  = request_service_flag_q;
   always_comb begin
      status_summary_byte_out              = summ_bits;
      status_summary_byte_out[`SB_SERVICE] = master_summary_flag;
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence s_hdr_take;
      qry_take && (fmt_q != SBSR_FMT_DEC);
   endsequence
   sequence s_hdr_first;
      rsp_valid_out && (rsp_char_out == `CH_HASH);
   endsequence
   a_summary_follow: assert property (
      status_summary_byte_out[`SB_ERR] == summary_in.error_queue_nonempty
      && poll_byte_out[`SB_UNUSED] == 1'b0)
      else $error("summary bit does not follow its input");
   a_master_enabled_or: assert property (
      status_summary_byte_out[`SB_SERVICE]
      == |(summ_bits & service_request_mask_q & 8'hbd))
      else $error("master summary differs from enabled OR");
   a_rise_sets_request: assert property (
      rise_any |=> srq_out)
      else $error("rising enabled bit did not raise request");
   a_poll_clears_request: assert property (
      poll_take && !rise_any |=> !srq_out)
      else $error("poll did not clear request flag");
   a_poll_reports_request: assert property (
      poll_take |=> poll_valid_out
      && poll_byte_out[`SB_SERVICE] == $past(request_service_flag_q))
      else $error("poll byte B6 is not the request flag");
   a_mask_write_value: assert property (
      cmd_take && cmd_in.op == SBSR_CMD_MASK_WRITE
      |=> service_request_mask_out == $past(cmd_in.data))
      else $error("mask write not stored");
   a_std_read_clear: assert property (
      qry_take && cmd_in.op == SBSR_CMD_STD_QUERY
      |=> std_event_clear_out ##1 !std_event_clear_out)
      else $error("standard event read gave no single clear");
   a_header_sent: assert property (
      s_hdr_take |=> s_hdr_first)
      else $error("non-decimal read-back lacks header");
   a_query_answers: assert property (
      qry_take |=> rsp_valid_out && !cmd_ready_out)
      else $error("query gave no response");

endmodule
`default_nettype wire
